/* File: shared/bsc_pkg.sv */
// bsc_pkg: constants for the bridge switch control block
// assumes: 16-bit frame, bit positions shared by command and status words
package bsc_pkg;
    localparam int unsigned FRAME_BITS      = 16;
    localparam int unsigned SWITCH_COUNT    = 12;
    localparam int unsigned SW_LSB          = 1;
    localparam int unsigned STATUS_RST_BIT  = 0;
    localparam int unsigned OC_BIT          = 13;
    localparam int unsigned OT_BIT          = 14;
    localparam int unsigned OV_BIT          = 15;
    localparam logic [11:0] SWITCH_RESET    = 12'h000;
    localparam logic [3:0]  BIT_COUNT_RESET = 4'h0;
    typedef enum logic [1:0] {BSC_NORMAL, BSC_BRAKE, BSC_STANDBY} bsc_mode_e;
endpackage : bsc_pkg

/* File: rtl/bsc_sync.sv */
// bsc_sync: two-flop synchroniser, one bit per lane
// assumes: inputs are asynchronous to ref_clk
module bsc_sync
    import bsc_pkg::*;
#(
    parameter int unsigned WIDTH = 1
)(
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            meta_r   <= '0;
            sync_out <= '0;
        end
        else if (clk_en)
        begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : bsc_sync

/* File: rtl/bsc_core.sv */
// bsc_core: serial command/status port, mode pins, fault flags, switch drive
// assumes: serial pins, mode pins and fault detectors are asynchronous to ref_clk
module bsc_core
    import bsc_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    reset,
    input  wire logic                    clk_en,
    input  wire logic                    chip_select_n,
    input  wire logic                    serial_clk,
    input  wire logic                    serial_in,
    output logic                         serial_out,
    input  wire logic                    mode_pin,
    input  wire logic                    select_pin,
    input  wire logic [SWITCH_COUNT-1:0] overcurrent_det,
    input  wire logic                    overtemp_det,
    input  wire logic                    overvoltage_det,
    output logic      [SWITCH_COUNT-1:0] power_transistor
);
    // synchronised pins; fault lanes pass through one two-flop stage of their own, alongside the pins
    logic [4:0]              pin_s;
    logic [SWITCH_COUNT+1:0] fault_s;

    // select travels inverted so that the lane's reset value reads as idle, not as a frame start
    bsc_sync #(.WIDTH(5)) u_pin_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .async_in ({~chip_select_n, serial_clk, serial_in, mode_pin, select_pin}),
        .sync_out (pin_s)
    );

    bsc_sync #(.WIDTH(SWITCH_COUNT + 2)) u_fault_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .async_in ({overcurrent_det, overtemp_det, overvoltage_det}),
        .sync_out (fault_s)
    );

    wire logic                    cs_n_s = !pin_s[4];
    wire logic                    sclk_s = pin_s[3];
    wire logic                    sin_s  = pin_s[2];
    wire logic                    mode_s = pin_s[1];
    wire logic                    sel_s  = pin_s[0];
    wire logic [SWITCH_COUNT-1:0] oc_det = fault_s[SWITCH_COUNT+1:2];
    wire logic                    ot_det = fault_s[1];
    wire logic                    ov_det = fault_s[0];

    logic                    cs_n_d_r;
    logic                    sclk_d_r;
    logic                    mode_d_r;
    logic                    sel_d_r;
    bsc_mode_e               mode_r;
    bsc_mode_e               mode_nxt;
    logic                    in_frame_r;
    logic [3:0]              bit_cnt_r;
    logic                    rx_any_r;
    logic [FRAME_BITS-1:0]   rx_r;
    logic [FRAME_BITS-1:0]   tx_r;
    logic [SWITCH_COUNT-1:0] cmd_r;
    logic [SWITCH_COUNT-1:0] oc_off_r;
    logic                    oc_flag_r;
    logic                    ot_flag_r;
    logic                    ov_flag_r;
    logic                    all_float_r;
    logic                    sout_r;

    // mode decode; standby is sticky against select so brake needs normal first
    always_comb
    begin
        case (mode_r)
            BSC_STANDBY: mode_nxt = mode_s ? BSC_NORMAL : BSC_STANDBY;
            default:     mode_nxt = mode_s ? BSC_NORMAL :
                                    (sel_s ? BSC_BRAKE : BSC_STANDBY);
        endcase
    end

    wire logic standby     = (mode_r == BSC_STANDBY);
    wire logic brake       = (mode_r == BSC_BRAKE);
    wire logic pins_change = (mode_s != mode_d_r) || (sel_s != sel_d_r);
    wire logic cs_fall     = cs_n_d_r && !cs_n_s;
    wire logic cs_rise     = !cs_n_d_r && cs_n_s;
    wire logic sclk_rise   = !sclk_d_r && sclk_s && !cs_n_s;
    wire logic sclk_fall   = sclk_d_r && !sclk_s && !cs_n_s;
    // a frame counts only if clocked, complete and not broken by a pin change;
    // an unclocked select pulse would otherwise re-apply the previous word
    wire logic frame_done  = cs_rise && in_frame_r && rx_any_r && !pins_change
                             && (bit_cnt_r == BIT_COUNT_RESET) && !standby;
    wire logic [FRAME_BITS-1:0] word = rx_r;
    wire logic status_rst  = frame_done && word[STATUS_RST_BIT] && word[OV_BIT];
    wire logic oc_clr      = frame_done && word[OC_BIT] && !status_rst;
    wire logic ot_clr      = frame_done && word[OT_BIT];
    wire logic ov_clr      = frame_done && word[OV_BIT];
    wire logic faults_on   = !standby;

    // high-side controls sit on even indices, low-side on odd (bits 1,2 = A1 H,L)
    function automatic logic [SWITCH_COUNT-1:0] drive_map(
        input logic [SWITCH_COUNT-1:0] ctl
    );
        logic [SWITCH_COUNT-1:0] d;
        d = '0;
        for (int i = 0; i < SWITCH_COUNT; i += 2)
        begin
            if (ctl[i] != ctl[i+1])
            begin
                d[i]   = ctl[i];
                d[i+1] = ctl[i+1];
            end
        end
        return d;
    endfunction : drive_map

    localparam logic [SWITCH_COUNT-1:0] LOW_SIDES = 12'hAAA;

    wire logic [SWITCH_COUNT-1:0] run_drive = drive_map(cmd_r) & ~oc_off_r;
    // thermal and overvoltage force off only while the detector is active
    wire logic live_fault = faults_on && (ot_det || ov_det);
    wire logic [SWITCH_COUNT-1:0] drive =
        standby     ? '0 :
        brake       ? LOW_SIDES :
        (all_float_r || live_fault) ? '0 : run_drive;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            cs_n_d_r <= 1'b1;
            sclk_d_r <= 1'b0;
            mode_d_r <= 1'b0;
            sel_d_r  <= 1'b0;
            mode_r   <= BSC_STANDBY;
        end
        else if (clk_en)
        begin
            cs_n_d_r <= cs_n_s;
            sclk_d_r <= sclk_s;
            mode_d_r <= mode_s;
            sel_d_r  <= sel_s;
            mode_r   <= mode_nxt;
        end
    end

    // serial shifter
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            in_frame_r <= 1'b0;
            bit_cnt_r  <= BIT_COUNT_RESET;
            rx_r       <= '0;
            rx_any_r   <= 1'b0;
            tx_r       <= '0;
            sout_r     <= 1'b0;
        end
        else if (clk_en)
        begin
            if (cs_fall)
            begin
                in_frame_r <= 1'b1;
                rx_any_r   <= 1'b0;
                bit_cnt_r  <= BIT_COUNT_RESET;
                tx_r       <= {ov_flag_r, ot_flag_r, oc_flag_r, power_transistor, 1'b0};
            end
            else if (pins_change || cs_n_s)
            begin
                in_frame_r <= 1'b0;
            end
            if (sclk_rise && in_frame_r)
            begin
                sout_r <= tx_r[FRAME_BITS-1];
                tx_r   <= {tx_r[FRAME_BITS-2:0], 1'b0};
            end
            if (sclk_fall && in_frame_r)
            begin
                rx_r      <= {rx_r[FRAME_BITS-2:0], sin_s};
                bit_cnt_r <= bit_cnt_r + 4'h1;
                rx_any_r  <= 1'b1;
            end
        end
    end

    // command store and outputs
    always_ff @(posedge ref_clk)
    begin
        if (reset || (clk_en && standby))
        begin
            cmd_r       <= SWITCH_RESET;
            all_float_r <= 1'b0;
        end
        else if (clk_en && frame_done)
        begin
            if (status_rst)
            begin
                cmd_r       <= SWITCH_RESET;
                all_float_r <= 1'b1;
            end
            else
            begin
                cmd_r       <= word[SWITCH_COUNT:SW_LSB];
                all_float_r <= 1'b0;
            end
        end
    end

    // sticky fault flags; a detection in the clear cycle wins
    always_ff @(posedge ref_clk)
    begin
        if (reset || (clk_en && standby))
        begin
            oc_flag_r <= 1'b0;
            ot_flag_r <= 1'b0;
            ov_flag_r <= 1'b0;
            oc_off_r  <= '0;
        end
        else if (clk_en)
        begin
            oc_flag_r <= (faults_on && |oc_det) || (oc_flag_r && !oc_clr && !status_rst);
            ot_flag_r <= (faults_on && ot_det) || (ot_flag_r && !ot_clr && !status_rst);
            ov_flag_r <= (faults_on && ov_det) || (ov_flag_r && !ov_clr && !status_rst);
            oc_off_r  <= (faults_on ? oc_det : '0)
                         | ((oc_clr || status_rst) ? '0 : oc_off_r);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            power_transistor <= '0;
        end
        else if (clk_en)
        begin
            power_transistor <= drive;
        end
    end

    assign serial_out = sout_r;

    // assertions
    standby_all_off_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && standby |=> power_transistor == '0)
        else $error("standby did not turn all transistors off");
    brake_low_on_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && brake |=> power_transistor == LOW_SIDES)
        else $error("brake drive pattern wrong");
    no_shoot_a: assert property (@(posedge ref_clk) disable iff (reset)
        (power_transistor & (power_transistor >> 1) & 12'h555) == '0)
        else $error("both transistors of a half-bridge on");
    oc_sticky_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && oc_flag_r && !oc_clr && !status_rst && !standby |=> oc_flag_r)
        else $error("overcurrent flag dropped without clear");
    ot_sticky_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && ot_flag_r && !ot_clr && !status_rst && !standby |=> ot_flag_r)
        else $error("overtemp flag dropped without clear");
    ov_set_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && faults_on && ov_det |=> ov_flag_r)
        else $error("overvoltage not flagged");
    standby_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && standby && !mode_s |=> mode_r == BSC_STANDBY)
        else $error("left standby without mode high");
    status_float_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && status_rst && !ot_det && !ov_det && mode_r == BSC_NORMAL
        && mode_s ##1 clk_en |=> power_transistor == '0)
        else $error("status reset left outputs driven");
    abort_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && pins_change && !cs_fall |=> !in_frame_r)
        else $error("frame applied despite pin change");
    frame_c: cover property (@(posedge ref_clk) frame_done && !status_rst);
    status_rst_c: cover property (@(posedge ref_clk) status_rst);
    brake_c: cover property (@(posedge ref_clk) brake);
    oc_c: cover property (@(posedge ref_clk) oc_clr && oc_flag_r);
endmodule : bsc_core

/* File: tb/bsc_host.sv */
// bsc_host: serial master model, drives chip select, link clock and command bit
// assumes: ref_clk from the bench; link clock 32 ns, held low outside frames
module bsc_host
    import bsc_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic serial_out,
    output logic      chip_select_n,
    output logic      serial_clk,
    output logic      serial_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        chip_select_n = 1'b1;
        serial_clk    = 1'b0;
        serial_in     = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : hold

    // status bit is read late in the low half, well after the device answers
    task automatic frame(input logic [15:0] cmd, output logic [15:0] st);
        chip_select_n = 1'b0;
        hold(4);
        for (int i = FRAME_BITS - 1; i >= 0; i--)
        begin
            serial_clk = 1'b1;
            serial_in  = cmd[i];
            hold(4);
            serial_clk = 1'b0;
            hold(4);
            st[i] = serial_out;
        end
        chip_select_n = 1'b1;
        serial_in     = 1'b0;
        hold(4);
    endtask : frame
endmodule : bsc_host

/* File: tb/bridge_switch_control_faults_bench.sv */
// bench for bsc_core: random and corner frames, fault flags, mode pins
// assumes: bsc_host as serial master; clk_en high except in one freeze scenario
module bridge_switch_control_faults_bench;
    import bsc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk;
    logic        reset;
    logic        clk_en;
    logic        mode_pin;
    logic        select_pin;
    logic [11:0] overcurrent_det;
    logic        overtemp_det;
    logic        overvoltage_det;
    logic        chip_select_n;
    logic        serial_clk;
    logic        serial_in;
    logic        serial_out;
    logic [11:0] power_transistor;
    logic [15:0] st;
    logic [15:0] cmd;
    logic [11:0] drv;
    int          num_errors      = 0;
    int          n_checks        = 0;

    always #2 ref_clk = ~ref_clk;

    bsc_core dut (
        .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .chip_select_n(chip_select_n),
        .serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out),
        .mode_pin(mode_pin), .select_pin(select_pin), .overcurrent_det(overcurrent_det),
        .overtemp_det(overtemp_det), .overvoltage_det(overvoltage_det),
        .power_transistor(power_transistor)
    );

    bsc_host host (
        .ref_clk(ref_clk), .serial_out(serial_out), .chip_select_n(chip_select_n),
        .serial_clk(serial_clk), .serial_in(serial_in)
    );

    function automatic logic [11:0] drive_of(input logic [15:0] c);
        logic [11:0] d;
        d = c[12:1];
        for (int k = 0; k < 6; k++)
        begin
            if (d[2*k] && d[2*k+1])
                d[2*k +: 2] = 2'b00;
        end
        return d;
    endfunction : drive_of

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic pt_is(input logic [11:0] e);
        host.hold(10);
        chk({4'h0, power_transistor}, {4'h0, e});
    endtask : pt_is

    task automatic fault(input int j, input logic v);
        case (j)
            0: overcurrent_det = {11'h000, v};
            1: overtemp_det = v;
            default: overvoltage_det = v;
        endcase
    endtask : fault

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        tally_and_finish();
    end

    initial
    begin
        ref_clk         = 1'b0;
        reset           = 1'b1;
        clk_en          = 1'b1;
        mode_pin        = 1'b0;
        select_pin      = 1'b0;
        overcurrent_det = 12'h000;
        overtemp_det    = 1'b0;
        overvoltage_det = 1'b0;
        void'($urandom(32'h3613));
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        reset    = 1'b0;
        mode_pin = 1'b1;
        host.hold(8);
        drv = 12'h000;
        // each status word echoes the drive set by the frame before it
        for (int n = 0; n < 16; n++)
        begin
            select_pin = 1'($urandom());
            host.hold(4);
            cmd = {3'b000, 12'($urandom()), 1'b0};
            if (n < 6)
                cmd[2*n+1 +: 2] = 2'b11;
            host.frame(cmd, st);
            chk(st, {3'b000, drv, 1'b0});
            drv = drive_of(cmd);
            pt_is(drv);
        end
        // faults: overcurrent stays off until cleared, the others resume on recovery
        host.frame(16'h0012, st);
        for (int j = 0; j < 3; j++)
        begin
            fault(j, 1'b1);
            pt_is(j == 0 ? 12'h008 : 12'h000);
            host.frame(16'h0012, st);
            chk(st, (16'h2000 << j) | (j == 0 ? 16'h0010 : 16'h0000));
            fault(j, 1'b0);
            drv = (j == 0) ? 12'h008 : 12'h009;
            pt_is(drv);
            host.frame(16'h0012 | (16'h2000 << j), st);
            chk(st, (16'h2000 << j) | {3'b000, drv, 1'b0});
            pt_is(12'h009);
            host.frame(16'h0012, st);
            chk(st, 16'h0012);
        end
        // clock enable low freezes everything: a fault pulse meanwhile leaves no trace
        clk_en = 1'b0;
        fault(1, 1'b1);
        pt_is(12'h009);
        host.hold(int'($urandom() % 8));
        fault(1, 1'b0);
        host.hold(2);
        clk_en = 1'b1;
        host.frame(16'h0012, st);
        chk(st, 16'h0012);
        fault(1, 1'b1);
        host.hold(10);
        fault(1, 1'b0);
        host.frame(16'h0013, st);
        pt_is(12'h009);
        host.frame(16'h8013, st);
        chk(st, 16'h4012);
        pt_is(12'h000);
        host.frame(16'h0000, st);
        chk(st, 16'h0000);
        host.frame(16'h0012, st);
        // a select change in mid-frame must leave the old drive in place
        fork
            host.frame(16'h0FFE, st);
            begin
                host.hold(40);
                select_pin = ~select_pin;
            end
        join
        pt_is(12'h009);
        select_pin = 1'b1;
        host.hold(8);
        mode_pin = 1'b0;
        pt_is(12'hAAA);
        mode_pin = 1'b1;
        pt_is(12'h009);
        mode_pin = 1'b0;
        pt_is(12'hAAA);
        select_pin = 1'b0;
        pt_is(12'h000);
        select_pin = 1'b1;
        fault(1, 1'b1);
        pt_is(12'h000);
        fault(1, 1'b0);
        select_pin = 1'b0;
        host.hold(4);
        mode_pin = 1'b1;
        pt_is(12'h000);
        host.frame(16'h0012, st);
        chk(st, 16'h0000);
        pt_is(12'h009);
        tally_and_finish();
    end
endmodule : bridge_switch_control_faults_bench
